// File: hw/pevq_counter.sv
// file: event counter accumulator fed by the qualifier's per-cycle increment
`timescale 1ns/100ps
`default_nettype none

module pevq_counter #(
  parameter int CNT_W = 40,
  parameter int INC_W = 3
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // increment from the qualifier
  input wire logic [INC_W-1:0] inc_i,
  // running count
  output logic [CNT_W-1:0] count_o
);

  // wraps silently; overflow handling lives outside this block
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_o <= '0;
    end else begin
      count_o <= count_o + CNT_W'(inc_i);
    end
  end

endmodule

`default_nettype wire

// File: hw/pevq_qualifier.sv
// file: event selection and unit-mask qualification driving one performance counter
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - feature query reports unavailable predefined events in an eight-bit field
// R2 - select 3C mask 00 counts one per unhalted core clock cycle
// R3 - core cycles stop outside C0, halt, stop clock, throttle, frequency switch
// R4 - core cycles keep counting across performance-state changes at current frequency
// R5 - select C0 mask 00 counts instructions at final micro-op retirement
// R6 - repeated string counts once; faults before final micro-op count nothing
// R7 - no count on VM exit; counts through interrupts, traps and handlers
// R8 - select 3C mask 01 counts fixed reference ticks while core runs
// R9 - select 2E mask 4F counts this core's cache references, no prefetch fills
// R10 - select 2E mask 41 counts cache misses, excluding prefetch fills
// R11 - select C4 mask 00 counts retired branches at final micro-op
// R12 - select C5 mask 00 counts retired mispredicted branches
// R13 - unit mask bits 15:8 decode into topology qualification sub-fields
// R14 - bits 15:14: 11 all cores, 01 this core, others reserved
// R15 - bit 13: 0 this agent only, 1 all bus agents
// R16 - core-only conditions get no core or agent qualification
// R17 - bits 13:12: 11 all, 01 prefetch only, 00 no prefetch, 10 reserved
// R18 - no qualification, core plus agent, or core plus prefetch; never both
// R19 - bits 11:8 enable modified, exclusive, shared, invalid line states
// R20 - state-qualified event with no state bit set never increments
// R21 - counter adds the qualifying occurrences each cycle, else holds
module pevq_qualifier
  import pevq_pkg::*;
#(
  parameter int RET_N = 4,
  parameter int LLC_N = 4,
  parameter int CNT_W = 40,
  parameter logic [CORE_ID_W-1:0] THIS_CORE = '0,
  parameter logic [7:0] UNAVAIL_MASK = UNAVAIL_RST
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // event-select register fields and qualification kind of the selected event
  input wire pevq_pkg::pevq_cfg_t cfg_i,
  input wire pevq_pkg::pevq_qual_t qual_kind_i,
  input wire logic mesi_required_i,
  // core clocking status and fixed-rate reference tick
  input wire pevq_pkg::pevq_core_st_t core_st_i,
  input wire logic ref_tick_i,
  // retirement and cache sources
  input wire pevq_pkg::pevq_ret_slot_t [RET_N-1:0] ret_i,
  input wire logic vm_exit_i,
  input wire pevq_pkg::pevq_llc_slot_t [LLC_N-1:0] llc_i,
  // results
  output logic [31:0] feature_query_o,
  output logic event_known_o,
  output logic [$clog2((RET_N > LLC_N ? RET_N : LLC_N) + 1)-1:0] inc_o,
  output logic [CNT_W-1:0] count_o
);

  localparam int MAX_N = (RET_N > LLC_N) ? RET_N : LLC_N;
  localparam int INC_W = $clog2(MAX_N + 1);

  // every check below samples on the core clock and sleeps through reset
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic core_running;
  logic sel_core_cyc;
  logic sel_ref_cyc;
  logic sel_instr;
  logic sel_br;
  logic sel_br_miss;
  logic sel_llc;
  logic llc_arch;
  logic [RET_N-1:0] instr_hit;
  logic [RET_N-1:0] br_hit;
  logic [RET_N-1:0] miss_hit;
  logic [LLC_N-1:0] llc_hit;
  logic [1:0] core_code;
  logic [1:0] pf_code;
  logic agent_all;
  logic [3:0] mesi_en;
  pevq_qual_t eff_kind;
  logic eff_mesi;
  logic [INC_W-1:0] next_inc;
  logic [INC_W-1:0] br_cnt;

  // population count of a qualified slot vector
  function automatic logic [INC_W-1:0] count_ones(input logic [MAX_N-1:0] v);
    logic [INC_W-1:0] n;
    n = '0;
    for (int k = 0; k < MAX_N; k++) begin
      n = n + INC_W'(v[k]);
    end
    return n;
  endfunction

  // core clock considered running only in full operation
  assign core_running = core_st_i.in_c0 && !core_st_i.halt_instruction &&
                        !core_st_i.stop_clock_input && !core_st_i.thermal_throttle_mode &&
                        !core_st_i.freq_switch; // [R3]

  // event decode of the predefined selections
  assign sel_core_cyc = (cfg_i.evt_sel == EVT_CORE_CYC) && (cfg_i.umask == UM_NONE); // [R2]
  assign sel_ref_cyc = (cfg_i.evt_sel == EVT_CORE_CYC) && (cfg_i.umask == UM_REF_CYC); // [R8]
  assign sel_instr = (cfg_i.evt_sel == EVT_INSTR_RET) && (cfg_i.umask == UM_NONE); // [R5]
  assign sel_br = (cfg_i.evt_sel == EVT_BR_RET) && (cfg_i.umask == UM_NONE); // [R11]
  assign sel_br_miss = (cfg_i.evt_sel == EVT_BR_MISS) && (cfg_i.umask == UM_NONE); // [R12]
  assign sel_llc = (cfg_i.evt_sel == EVT_LLC);
  assign llc_arch = sel_llc && ((cfg_i.umask == UM_LLC_REF) || (cfg_i.umask == UM_LLC_MISS));

  // unit-mask sub-fields
  assign core_code = cfg_i.umask[UM_CORE_HI:UM_CORE_LO]; // [R13] [R14]
  assign pf_code = cfg_i.umask[UM_PF_HI:UM_PF_LO]; // [R17]
  assign agent_all = cfg_i.umask[UM_AGENT]; // [R15]
  assign mesi_en = cfg_i.umask[UM_MESI_HI:UM_MESI_LO]; // [R19]

  // architectural cache events always take core plus prefetch plus state qualification;
  // their masks then read as this core, no prefetch, all states or invalid only
  always_comb begin
    eff_kind = qual_kind_i;
    eff_mesi = mesi_required_i;
    if (llc_arch) begin
      eff_kind = PEVQ_Q_CORE_PF; // [R9] [R10]
      eff_mesi = 1'b1;
    end
  end

  // retirement slot qualification, one per slot
  generate
    for (genvar g = 0; g < RET_N; g++) begin : g_ret
      // only the final micro-op retires an instruction, so string loops count once
      assign instr_hit[g] = ret_i[g].valid && ret_i[g].last_uop && !ret_i[g].faulted; // [R6]
      assign br_hit[g] = instr_hit[g] && ret_i[g].branch; // [R11]
      assign miss_hit[g] = br_hit[g] && ret_i[g].mispredict; // [R12]
    end
  endgenerate

  // cache and bus slot qualification, one per slot
  generate
    for (genvar g = 0; g < LLC_N; g++) begin : g_llc
      logic core_ok;
      logic agent_ok;
      logic pf_ok;
      logic state_ok;
      // reserved core codes qualify nothing
      always_comb begin
        case (core_code)
          CORE_ALL: core_ok = 1'b1; // [R14]
          CORE_THIS: core_ok = (llc_i[g].core_id == THIS_CORE); // [R14]
          default: core_ok = 1'b0;
        endcase
      end
      assign agent_ok = agent_all || llc_i[g].this_agent; // [R15]
      // prefetch code 10 is reserved and qualifies nothing
      always_comb begin
        case (pf_code)
          PF_ALL: pf_ok = 1'b1; // [R17]
          PF_ONLY: pf_ok = llc_i[g].hw_prefetch; // [R17]
          PF_EXCL: pf_ok = !llc_i[g].hw_prefetch; // [R17]
          default: pf_ok = 1'b0;
        endcase
      end
      // an empty state sub-field blocks a state-qualified event outright
      assign state_ok = !eff_mesi || |(mesi_en & llc_i[g].line_state); // [R19] [R20]
      // agent and prefetch readings of bit 13 are exclusive by the kind encoding
      always_comb begin
        case (eff_kind)
          PEVQ_Q_NONE: llc_hit[g] = llc_i[g].valid && state_ok; // [R16] [R18]
          PEVQ_Q_CORE_AGENT: llc_hit[g] = llc_i[g].valid && core_ok && agent_ok && state_ok; // [R18]
          PEVQ_Q_CORE_PF: llc_hit[g] = llc_i[g].valid && core_ok && pf_ok && state_ok; // [R18]
          default: llc_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // branch count shared by the increment and the mispredict bound check
  assign br_cnt = count_ones(MAX_N'(br_hit)); // [R11]

  // per-cycle increment of the selected event
  always_comb begin
    next_inc = '0;
    if (sel_core_cyc) begin
      // rate follows the live core clock, so p-state changes need no special case
      next_inc = INC_W'(core_running); // [R2] [R3] [R4]
    end else if (sel_ref_cyc) begin
      next_inc = INC_W'(core_running && ref_tick_i); // [R8]
    end else if (sel_instr) begin
      // interrupts and traps retire normally; only a vm exit is suppressed
      next_inc = vm_exit_i ? '0 : count_ones(MAX_N'(instr_hit)); // [R5] [R7]
    end else if (sel_br) begin
      next_inc = br_cnt; // [R11]
    end else if (sel_br_miss) begin
      next_inc = count_ones(MAX_N'(miss_hit)); // [R12]
    end else if (sel_llc) begin
      next_inc = count_ones(MAX_N'(llc_hit)); // [R9] [R10] [R13]
    end
  end

  // registered increment; one cycle of latency keeps the adder off the source paths
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      inc_o <= '0;
    end else begin
      inc_o <= next_inc; // [R21]
    end
  end

  // selection recognised flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      event_known_o <= 1'b0;
    end else begin
      event_known_o <= sel_core_cyc || sel_ref_cyc || sel_instr || sel_br ||
                       sel_br_miss || sel_llc;
    end
  end

  // feature-query word; only the unavailable-event field is populated here
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      feature_query_o <= '0;
    end else begin
      feature_query_o <= '0;
      feature_query_o[FQ_UNAVAIL_HI:FQ_UNAVAIL_LO] <= UNAVAIL_MASK; // [R1]
    end
  end

  // accumulator
  pevq_counter #(
    .CNT_W(CNT_W),
    .INC_W(INC_W)
  ) u_counter (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .inc_i(inc_o),
    .count_o(count_o)
  );

  // checks
  logic past_valid;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  a_unavail_field: assert property ( // [R1]
    past_valid |-> feature_query_o[FQ_UNAVAIL_HI:FQ_UNAVAIL_LO] == UNAVAIL_MASK)
    else $error("unavailable-event field wrong");

  a_core_cycle_one: assert property ( // [R2]
    sel_core_cyc && core_running |=> inc_o == INC_W'(1))
    else $error("running core cycle not counted");

  a_core_cycle_gate: assert property ( // [R3]
    sel_core_cyc && (core_st_i.halt_instruction || !core_st_i.in_c0 ||
      core_st_i.stop_clock_input || core_st_i.thermal_throttle_mode ||
      core_st_i.freq_switch) |=> inc_o == '0)
    else $error("core cycle counted while stopped");

  a_ref_cycle_tick: assert property ( // [R8]
    sel_ref_cyc |=> inc_o == INC_W'($past(ref_tick_i) && $past(core_running)))
    else $error("reference cycle count mismatch");

  a_vm_exit_block: assert property ( // [R7]
    sel_instr && vm_exit_i |=> inc_o == '0)
    else $error("instructions counted on vm exit");

  a_fault_no_count: assert property ( // [R6]
    sel_instr && !vm_exit_i && (instr_hit == '0) |=> inc_o == '0)
    else $error("instruction counted without clean final micro-op");

  a_miss_le_branch: assert property ( // [R12]
    sel_br_miss |=> inc_o <= $past(br_cnt))
    else $error("more mispredicts than branches");

  a_mesi_empty: assert property ( // [R20]
    sel_llc && eff_mesi && (mesi_en == '0) |=> inc_o == '0)
    else $error("state-qualified event counted with no state bit");

  a_core_reserved: assert property ( // [R14]
    sel_llc && (eff_kind != PEVQ_Q_NONE) && !core_code[0] |=> inc_o == '0)
    else $error("reserved core code counted");

  a_pf_reserved: assert property ( // [R17]
    sel_llc && (eff_kind == PEVQ_Q_CORE_PF) && (pf_code == 2'h2) |=> inc_o == '0)
    else $error("reserved prefetch code counted");

  a_count_accum: assert property ( // [R21]
    past_valid |=> count_o == CNT_W'($past(count_o) + CNT_W'($past(inc_o))))
    else $error("counter did not add increment");

  a_idle_hold: assert property ( // [R21]
    !event_known_o && (inc_o == '0) |=> $stable(count_o))
    else $error("counter moved with no selected event");

  c_core_stall: cover property (sel_core_cyc && core_running ##1 sel_core_cyc && !core_running);
  c_multi_retire: cover property (sel_instr ##1 inc_o > INC_W'(1));
  c_llc_miss: cover property (llc_arch && (cfg_i.umask == UM_LLC_MISS) ##1 inc_o != '0);
  c_br_miss: cover property (sel_br_miss ##1 inc_o != '0);

endmodule

`default_nettype wire

// File: inc/pevq_pkg.sv
// package: encodings, field positions and carrier types for the event qualifier
package pevq_pkg;

  // event select codes of the predefined events
  localparam logic [7:0] EVT_CORE_CYC = 8'h3c;
  localparam logic [7:0] EVT_INSTR_RET = 8'hc0;
  localparam logic [7:0] EVT_LLC = 8'h2e;
  localparam logic [7:0] EVT_BR_RET = 8'hc4;
  localparam logic [7:0] EVT_BR_MISS = 8'hc5;

  // unit masks of the predefined events
  localparam logic [7:0] UM_NONE = 8'h00;
  localparam logic [7:0] UM_REF_CYC = 8'h01;
  localparam logic [7:0] UM_LLC_REF = 8'h4f;
  localparam logic [7:0] UM_LLC_MISS = 8'h41;

  // unit-mask sub-field positions (within the 8-bit unit mask, bits 15:8 of the register)
  localparam int UM_CORE_HI = 7;
  localparam int UM_CORE_LO = 6;
  localparam int UM_AGENT = 5;
  localparam int UM_PF_HI = 5;
  localparam int UM_PF_LO = 4;
  localparam int UM_MESI_HI = 3;
  localparam int UM_MESI_LO = 0;

  // core-specificity codes
  localparam logic [1:0] CORE_ALL = 2'h3;
  localparam logic [1:0] CORE_THIS = 2'h1;

  // prefetch qualification codes
  localparam logic [1:0] PF_ALL = 2'h3;
  localparam logic [1:0] PF_ONLY = 2'h1;
  localparam logic [1:0] PF_EXCL = 2'h0;

  // line state bit positions within the one-hot state and the mesi sub-field
  localparam int ST_INV = 0;
  localparam int ST_SHR = 1;
  localparam int ST_EXC = 2;
  localparam int ST_MOD = 3;

  // feature-query field carrying the unavailable-event mask
  localparam int FQ_UNAVAIL_HI = 31;
  localparam int FQ_UNAVAIL_LO = 24;
  localparam logic [7:0] UNAVAIL_RST = 8'h00;

  // width of the core identifier in cache request slots
  localparam int CORE_ID_W = 2;

  // which topology qualification an event accepts; agent and prefetch never meet
  typedef enum logic [2:0] {
    PEVQ_Q_NONE = 3'b001,
    PEVQ_Q_CORE_AGENT = 3'b010,
    PEVQ_Q_CORE_PF = 3'b100
  } pevq_qual_t;

  // event-select register fields that reach the block
  typedef struct packed {
    logic [7:0] umask;
    logic [7:0] evt_sel;
  } pevq_cfg_t;

  // core clocking status
  typedef struct packed {
    logic in_c0;
    logic halt_instruction;
    logic stop_clock_input;
    logic thermal_throttle_mode;
    logic freq_switch;
  } pevq_core_st_t;

  // one retirement slot of the pipeline
  typedef struct packed {
    logic valid;
    logic last_uop;
    logic faulted;
    logic branch;
    logic mispredict;
  } pevq_ret_slot_t;

  // one cache or bus request slot
  typedef struct packed {
    logic valid;
    logic [CORE_ID_W-1:0] core_id;
    logic this_agent;
    logic hw_prefetch;
    logic [3:0] line_state;
  } pevq_llc_slot_t;

endpackage

// File: testbench/perf_event_qualifier_tb.sv
// self-checking bench for the event qualifier and its counter
`timescale 1ns/100ps
`default_nettype none

module perf_event_qualifier_tb;
  import pevq_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i;
  pevq_cfg_t cfg, s_cfg;
  logic [2:0] kind, s_kind, n_ret, s_n;
  logic mesi, s_mesi, vm, s_vm;
  logic [1:0] rk, s_k;
  pevq_core_st_t st, s_st;
  pevq_llc_slot_t [3:0] llc, s_llc;
  pevq_ret_slot_t [3:0] ret;
  logic tick, known;
  logic [31:0] fq;
  logic [2:0] inc;
  logic [39:0] count;
  int err_total = 0;
  int checked = 0;

  // core clock, 50 ns period
  always #25 ref_clk_i = ~ref_clk_i;

  pevq_src_model pevq_src_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .n_ret_i(n_ret),
    .kind_i(rk), .ret_o(ret), .ref_tick_o(tick));

  // nonzero mask so the feature field cannot pass by resetting to zero
  pevq_qualifier #(.UNAVAIL_MASK(8'h5a)) pevq_qualifier_inst (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .cfg_i(cfg), .qual_kind_i(pevq_qual_t'(kind)), .mesi_required_i(mesi),
    .core_st_i(st), .ref_tick_i(tick), .ret_i(ret), .vm_exit_i(vm), .llc_i(llc),
    .feature_query_o(fq), .event_known_o(known), .inc_o(inc), .count_o(count));

  task complete_run;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // shadows reach the ports together on a rising edge
  task drive;
    @(posedge ref_clk_i);
    cfg <= s_cfg;
    kind <= s_kind;
    mesi <= s_mesi;
    st <= s_st;
    vm <= s_vm;
    n_ret <= s_n;
    rk <= s_k;
    llc <= s_llc;
  endtask

  // one sampled cycle, increment judged once it has registered
  task apply(input logic [2:0] exp);
    drive();
    @(posedge ref_clk_i);
    #1;
    chk(40'(inc), 40'(exp));
    chk(40'(known), 40'h1);
  endtask

  // n cycles of the current shadows, judged by the count's growth
  task burst(input int n, input logic [39:0] delta);
    logic [39:0] c0;
    pevq_cfg_t keep;
    keep = s_cfg;
    s_cfg = '0;
    repeat (3) drive();
    @(posedge ref_clk_i);
    #1;
    c0 = count;
    chk(40'(known), 40'h0);
    s_cfg = keep;
    repeat (n) drive();
    s_cfg = '0;
    drive();
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(count, c0 + delta);
  endtask

  task automatic t_core;
    logic [4:0] sv [6] = '{5'h10, 5'h00, 5'h18, 5'h14, 5'h12, 5'h11};
    logic [2:0] ex [6] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    s_cfg = {UM_NONE, EVT_CORE_CYC};
    for (int i = 0; i < 6; i++) begin
      s_st = sv[i];
      apply(ex[i]);
    end
    s_st = 5'h10;
    burst(5, 40'h5);
    // an unrecognised mask on a known select must leave the count alone
    s_cfg = {8'h02, EVT_CORE_CYC};
    burst(4, 40'h0);
  endtask

  task t_ref;
    s_cfg = {UM_REF_CYC, EVT_CORE_CYC};
    s_st = 5'h10;
    burst(8, 40'h2);
    s_st = 5'h18;
    burst(8, 40'h0);
  endtask

  task automatic t_instr;
    logic [7:0] sl [10] = '{8'hc0, 8'hc0, 8'hc0, 8'hc0, 8'hc4, 8'hc5, 8'hc5, 8'hc4, 8'hc4, 8'hc0};
    logic [2:0] nn [10] = '{3'h3, 3'h4, 3'h4, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3};
    logic [1:0] kk [10] = '{2'h0, 2'h0, 2'h3, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
    logic [2:0] ex [10] = '{3'h3, 3'h4, 3'h0, 3'h0, 3'h2, 3'h0, 3'h3, 3'h3, 3'h0, 3'h3};
    for (int i = 0; i < 10; i++) begin
      s_cfg = {UM_NONE, sl[i]};
      s_n = nn[i];
      s_k = kk[i];
      s_vm = (i == 3);
      apply(ex[i]);
    end
    s_vm = 1'b0;
    s_n = 3'h0;
  endtask

  function automatic pevq_llc_slot_t mk(logic [1:0] c, logic a, logic p, logic [3:0] s);
    return {1'b1, c, a, p, s};
  endfunction

  task automatic t_llc;
    logic [7:0] um [16] = '{8'h4f, 8'h41, 8'hc0, 8'he0, 8'h60, 8'h00, 8'h80, 8'h00,
      8'hd0, 8'hf0, 8'hc0, 8'he0, 8'h08, 8'h01, 8'h06, 8'h00};
    logic [2:0] kd [16] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1,
      3'h4, 3'h4, 3'h4, 3'h4, 3'h1, 3'h1, 3'h1, 3'h1};
    logic [2:0] ex [16] = '{3'h2, 3'h1, 3'h2, 3'h4, 3'h3, 3'h0, 3'h0, 3'h4,
      3'h1, 3'h4, 3'h3, 3'h0, 3'h1, 3'h3, 3'h0, 3'h0};
    // mixed cores, agents, prefetches and line states; this core is 0
    s_llc[0] = mk(2'h0, 1'b1, 1'b0, 4'h8);
    s_llc[1] = mk(2'h0, 1'b1, 1'b1, 4'h1);
    s_llc[2] = mk(2'h1, 1'b0, 1'b0, 4'h1);
    s_llc[3] = mk(2'h0, 1'b0, 1'b0, 4'h1);
    for (int i = 0; i < 16; i++) begin
      s_cfg = {um[i], EVT_LLC};
      s_kind = kd[i];
      s_mesi = (i >= 12);
      apply(ex[i]);
    end
  endtask

  task t_reset;
    @(posedge ref_clk_i);
    #1;
    chk(40'(fq), {8'h5a, 24'h000000});
    // reset raised and dropped on rising edges, held for one sampled edge
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    chk(count, 40'h0);
    chk(40'(fq), 40'h0);
    chk(40'(inc), 40'h0);
  endtask

  // watchdog, far beyond the roughly 130 cycles the tests take
  initial begin
    #250000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    s_cfg = '0;
    s_kind = 3'h1;
    s_mesi = 1'b0;
    s_st = 5'h10;
    s_vm = 1'b0;
    s_n = 3'h0;
    s_k = 2'h0;
    s_llc = '0;
    cfg = '0;
    kind = 3'h1;
    mesi = 1'b0;
    st = 5'h10;
    vm = 1'b0;
    n_ret = 3'h0;
    rk = 2'h0;
    llc = '0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_core();
    t_ref();
    t_instr();
    t_llc();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire

// File: testbench/pevq_src_model.sv
// source model: retirement slots and a free-running reference tick
`timescale 1ns/100ps
`default_nettype none

module pevq_src_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // how many slots retire and of what kind
  input wire logic [2:0] n_ret_i,
  input wire logic [1:0] kind_i,
  // sources seen by the qualifier
  output var pevq_pkg::pevq_ret_slot_t [3:0] ret_o,
  output logic ref_tick_o
);
  import pevq_pkg::*;
  logic [1:0] div;
  // reference tick every fourth cycle, free of the core state, so gating is the qualifier's job
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end
  assign ref_tick_o = (div == 2'h3);
  // kind 3 is a non-final micro-op that faults, the rest retire their final micro-op
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ret_o[i].valid = (3'(i) < n_ret_i);
      ret_o[i].last_uop = (kind_i != 2'h3);
      ret_o[i].faulted = (kind_i == 2'h3);
      ret_o[i].branch = (kind_i == 2'h1) || (kind_i == 2'h2);
      ret_o[i].mispredict = (kind_i == 2'h2);
    end
  end
endmodule
`default_nettype wire
